//--- hdl/dcc_top.sv
// dma channel control: registers, request sensing, transfer engine
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
//
// Summary of operation
// - code 1100 auto, 1101 converter, 1110/1111 reserved
// - code 1011 timer 3 match triggers dual
// - acknowledge in read cycle or write cycle
// - acknowledge active high or active low
// - external request low level or falling edge
// - handshake settings only on channels 0, 1
// - cycle steal releases bus; burst back-to-back
// - size bit selects byte or word
// - interrupt enable gates channel interrupt request
// - end flag set on normal finish
// - end flag cleared by 0 after read
// - channel enable gates channel transfers
// - single address via acknowledge; peripherals dual
// - fixed orders 0,3,2,1 and 1,3,2,0
// - round robin, starting 0,3,2,1
// - alternating order, starting 1,3,2,0
// - address error sets its flag
// - address error flag cleared by 0 after read
// - nmi sets flag; cleared 0 after read
// - master enable gates all channels
// - count holds remaining transfers
// - addresses fixed, incremented or decremented by size
// - codes 0000, 0010, 0011 take external requests on channels 0, 1 only

module dcc_top
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register bus
	input wire logic [dcc_pkg::AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// external handshake
	input wire logic [1:0] transfer_request_n,
	output logic [1:0] transfer_acknowledge,
	// on-chip events
	input wire logic [3:0] sci_req_event,
	input wire logic [2:0] timer_match_a_event,
	input wire logic timer3_match_a_event,
	input wire logic conversion_end_event,
	input wire logic nmi_event,
	// memory side
	output logic [31:0] mem_addr,
	output logic mem_read,
	output logic mem_write,
	output logic mem_word,
	input wire logic [15:0] mem_rdata,
	output logic [15:0] mem_wdata,
	// channel interrupt requests
	output logic [3:0] channel_irq
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [3:0][15:0] ctl;
		logic [3:0][15:0] cnt;
		logic [3:0][31:0] sar;
		logic [3:0][31:0] dar;
		logic [3:0] te_arm;
		logic [3:0] pend;
		logic [1:0] pr;
		logic ae;
		logic nmi_abort_flag;
		logic master_enable;
		logic ae_arm;
		logic nmi_arm;
		logic [1:0] transfer_request_prev;
		dcc_phase_e ph;
		logic [1:0] ch;
		logic [15:0] hold;
		logic wait_r;
		logic [31:0] rdata;
		logic [1:0] ack;
		logic [31:0] maddr;
		logic mrd;
		logic mwr;
		logic mword;
		logic [15:0] wdata;
		logic [3:0] irq;
	} dcc_state_s;

	dcc_state_s s_q;
	dcc_state_s s_d;
	logic [3:0] allowed;
	logic [3:0] req;
	logic [3:0] hit;
	logic [15:0] ev;
	logic gv;
	logic [1:0] gch;
	logic done;
	dcc_sel_e sel;
	logic [1:0] ri;
	logic [31:0] rv;
	logic [15:0] w;
	logic [15:0] nc;
	logic [15:0] cw;
	logic [3:0] code;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic is_ext(input logic [3:0] c);
		return c == RS_EXT_DUAL || c == RS_EXT_TO_DEV ||
			c == RS_EXT_FROM_DEV;
	endfunction : is_ext

	function automatic logic is_single(input logic [3:0] c);
		return c == RS_EXT_TO_DEV || c == RS_EXT_FROM_DEV;
	endfunction : is_single

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8+:8] = wd[b*8+:8];
		return r;
	endfunction : merge

	function automatic dcc_sel_e sel_of(input logic [AW-1:0] a);
		dcc_sel_e r;
		r = SEL_NONE;
		if (a == OFS_OPCTL)
			r = SEL_OPCTL;
		else if (a[1:0] == 2'b00)
		begin
			if (a[AW-1:4] == OFS_CTL[AW-1:4])
				r = SEL_CTL;
			else if (a[AW-1:4] == OFS_CNT[AW-1:4])
				r = SEL_CNT;
			else if (a[AW-1:4] == OFS_SAR[AW-1:4])
				r = SEL_SAR;
			else if (a[AW-1:4] == OFS_DAR[AW-1:4])
				r = SEL_DAR;
		end
		return r;
	endfunction : sel_of

	function automatic logic [31:0] step(input logic [31:0] a,
		input logic [1:0] m, input logic word);
		logic [31:0] d;
		d = word ? 32'h00000002 : 32'h00000001;
		if (m == STEP_INC)
			return a + d;
		else if (m == STEP_DEC)
			return a - d;
		return a;
	endfunction : step

	// ------------------------------------------------------------
	// per-channel request sensing
	// ------------------------------------------------------------
	// event per source code; auto and reserved codes carry none
	assign ev = {2'b00, conversion_end_event, 1'b0, timer3_match_a_event,
		timer_match_a_event, sci_req_event, 4'h0};

	for (genvar i = 0; i < 4; i++)
	begin : g_ch
		logic [3:0] c;
		logic ext;
		logic pin_n;
		logic fall;
		assign c = s_q.ctl[i][F_RS+:4];
		assign ext = is_ext(c) && (i < 2);
		assign pin_n = (i < 2) ? transfer_request_n[i % 2] : 1'b1;
		assign fall = (i < 2) && s_q.transfer_request_prev[i % 2] && !pin_n;
		assign allowed[i] = s_q.master_enable && s_q.ctl[i][F_DE] &&
			!s_q.ctl[i][F_TE] && !s_q.ae && !s_q.nmi_abort_flag;
		assign hit[i] = ev[c] || (ext && s_q.ctl[i][F_DS] && fall);
		assign req[i] = allowed[i] && (c == RS_AUTO || s_q.pend[i] ||
			(ext && !s_q.ctl[i][F_DS] && !pin_n));
	end

	dcc_arb u_arb
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.mode(s_q.pr),
		.req(req),
		.served(done),
		.served_ch(s_q.ch),
		.grant_valid(gv),
		.grant_ch(gch)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		done = 1'b0;
		s_d.transfer_request_prev = transfer_request_n;
		sel = sel_of(avs_address);
		ri = avs_address[3:2];
		unique case (sel)
			SEL_OPCTL: rv = {22'h000000, s_q.pr, 5'h00, s_q.ae,
				s_q.nmi_abort_flag, s_q.master_enable};
			SEL_CTL: rv = {16'h0000, s_q.ctl[ri]};
			SEL_CNT: rv = {16'h0000, s_q.cnt[ri]};
			SEL_SAR: rv = s_q.sar[ri];
			SEL_DAR: rv = s_q.dar[ri];
			default: rv = 32'h00000000;
		endcase
		// one wait cycle, then the answer stands for one edge
		s_d.wait_r = 1'b1;
		if ((avs_read || avs_write) && s_q.wait_r)
		begin
			s_d.wait_r = 1'b0;
			s_d.rdata = rv;
		end
		if (avs_read && !s_q.wait_r)
		begin
			if (sel == SEL_CTL && s_q.ctl[ri][F_TE])
				s_d.te_arm[ri] = 1'b1;
			if (sel == SEL_OPCTL)
			begin
				s_d.ae_arm = s_q.ae_arm || s_q.ae;
				s_d.nmi_arm = s_q.nmi_arm || s_q.nmi_abort_flag;
			end
		end
		w = 16'h0000;
		nc = 16'h0000;
		if (avs_write && !s_q.wait_r)
		begin
			unique case (sel)
				SEL_OPCTL:
				begin
					w = 16'(merge({16'h0000, 6'h00, s_q.pr, 5'h00,
						s_q.ae, s_q.nmi_abort_flag, s_q.master_enable}, avs_writedata,
						avs_byteenable));
					s_d.pr = w[F_PR+:2];
					s_d.master_enable = w[F_DME];
					if (!w[F_AE] && s_q.ae_arm)
						s_d.ae = 1'b0;
					if (!w[F_NMI_ABORT_FLAG] && s_q.nmi_arm)
						s_d.nmi_abort_flag = 1'b0;
					s_d.ae_arm = 1'b0;
					s_d.nmi_arm = 1'b0;
				end
				SEL_CTL:
				begin
					w = 16'(merge({16'h0000, s_q.ctl[ri]}, avs_writedata,
						avs_byteenable));
					nc = w;
					nc[F_TE] = s_q.ctl[ri][F_TE] &&
						!(!w[F_TE] && s_q.te_arm[ri]);
					if (w[F_RS+:4] == RS_RSVD0 || w[F_RS+:4] == RS_RSVD1 ||
						w[F_RS+:4] == RS_RSVD2)
						nc[F_RS+:4] = s_q.ctl[ri][F_RS+:4];
					if (w[F_SM+:2] == STEP_RSVD)
						nc[F_SM+:2] = s_q.ctl[ri][F_SM+:2];
					if (w[F_DM+:2] == STEP_RSVD)
						nc[F_DM+:2] = s_q.ctl[ri][F_DM+:2];
					if (ri[1])
						nc[F_DS+:3] = s_q.ctl[ri][F_DS+:3];
					s_d.ctl[ri] = nc;
					s_d.te_arm[ri] = 1'b0;
				end
				SEL_CNT: s_d.cnt[ri] = 16'(merge({16'h0000, s_q.cnt[ri]},
					avs_writedata, avs_byteenable));
				SEL_SAR: s_d.sar[ri] = merge(s_q.sar[ri], avs_writedata,
					avs_byteenable);
				SEL_DAR: s_d.dar[ri] = merge(s_q.dar[ri], avs_writedata,
					avs_byteenable);
				default: s_d.rdata = s_q.rdata;
			endcase
		end
		// transfer engine; its flag sets follow the bus so they win
		cw = s_q.ctl[s_q.ch];
		unique case (s_q.ph)
			DCC_IDLE:
				if (gv)
				begin
					s_d.ch = gch;
					if (s_q.ctl[gch][F_TS] &&
						(s_q.sar[gch][0] || s_q.dar[gch][0]))
						s_d.ae = 1'b1;
					else if (is_single(s_q.ctl[gch][F_RS+:4]) && gch < 2'h2)
						s_d.ph = DCC_SINGLE;
					else
						s_d.ph = DCC_READ;
				end
			DCC_READ:
				if (!allowed[s_q.ch])
					s_d.ph = DCC_IDLE;
				else
				begin
					s_d.hold = mem_rdata;
					s_d.ph = DCC_WRITE;
				end
			DCC_WRITE, DCC_SINGLE:
				if (!allowed[s_q.ch])
					s_d.ph = DCC_IDLE;
				else
					done = 1'b1;
			DCC_GAP: s_d.ph = DCC_IDLE;
		endcase
		if (done)
		begin
			s_d.sar[s_q.ch] = step(s_q.sar[s_q.ch], cw[F_SM+:2], cw[F_TS]);
			s_d.dar[s_q.ch] = step(s_q.dar[s_q.ch], cw[F_DM+:2], cw[F_TS]);
			s_d.cnt[s_q.ch] = s_q.cnt[s_q.ch] - 16'h0001;
			s_d.pend[s_q.ch] = 1'b0;
			if (s_q.cnt[s_q.ch] == 16'h0001)
				s_d.ctl[s_q.ch][F_TE] = 1'b1;
			if (cw[F_TM] && req[s_q.ch] && s_q.cnt[s_q.ch] != 16'h0001)
				s_d.ph = (s_q.ph == DCC_SINGLE) ? DCC_SINGLE
					: DCC_READ;
			else
				s_d.ph = cw[F_TM] ? DCC_IDLE : DCC_GAP;
		end
		for (int i = 0; i < 4; i++)
			if (hit[i])
				s_d.pend[i] = 1'b1;
		if (nmi_event)
			s_d.nmi_abort_flag = 1'b1;
		// registered outputs follow the next phase
		code = s_d.ctl[s_d.ch][F_RS+:4];
		s_d.mrd = s_d.ph == DCC_READ ||
			(s_d.ph == DCC_SINGLE && code == RS_EXT_TO_DEV);
		s_d.mwr = s_d.ph == DCC_WRITE ||
			(s_d.ph == DCC_SINGLE && code == RS_EXT_FROM_DEV);
		s_d.maddr = s_d.mrd ? s_d.sar[s_d.ch] : s_d.dar[s_d.ch];
		s_d.mword = (s_d.mrd || s_d.mwr) && s_d.ctl[s_d.ch][F_TS];
		s_d.wdata = s_d.hold;
		for (int i = 0; i < 2; i++)
			s_d.ack[i] = s_d.ctl[i][F_AL] ^ (s_d.ch == i[1:0] &&
				is_ext(s_d.ctl[i][F_RS+:4]) && (s_d.ph == DCC_SINGLE ||
				(s_d.ph == DCC_READ && !s_d.ctl[i][F_AM]) ||
				(s_d.ph == DCC_WRITE && s_d.ctl[i][F_AM])));
		for (int i = 0; i < 4; i++)
			s_d.irq[i] = s_d.ctl[i][F_TE] && s_d.ctl[i][F_IE];
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.ctl <= {4{CTL_RST}};
			// request pins idle high, so no false edge after reset
			s_q.transfer_request_prev <= '1;
			s_q.wait_r <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_r;
	assign transfer_acknowledge = s_q.ack;
	assign mem_addr = s_q.maddr;
	assign mem_read = s_q.mrd;
	assign mem_write = s_q.mwr;
	assign mem_word = s_q.mword;
	assign mem_wdata = s_q.wdata;
	assign channel_irq = s_q.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence access_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence dual_s;
		mem_read ##1 mem_write;
	endsequence

	bus_answer_a: assert property (access_s |=> !avs_waitrequest)
		else $error("bus access not answered after one wait");
	end_set_a: assert property (done && s_q.ch == 2'h0 &&
		s_q.cnt[0] == 16'h0001 |=> s_q.ctl[0][F_TE] && channel_irq[0]
		== s_q.ctl[0][F_IE])
		else $error("end flag or interrupt missing at count end");
	end_hold_a: assert property (s_q.ctl[0][F_TE] &&
		!s_q.te_arm[0] |=> s_q.ctl[0][F_TE])
		else $error("end flag cleared without prior read");
	ae_hold_a: assert property (s_q.ae && !s_q.ae_arm |=> s_q.ae)
		else $error("address error flag cleared without read");
	nmi_hold_a: assert property (s_q.nmi_abort_flag && !s_q.nmi_arm |=>
		s_q.nmi_abort_flag)
		else $error("nmi flag cleared without read");
	halt_stop_a: assert property (s_q.ph == DCC_READ &&
		(!s_q.master_enable || s_q.nmi_abort_flag) |=> s_q.ph == DCC_IDLE && !mem_write)
		else $error("transfer kept running while stopped");
	ack_phase_a: assert property ((transfer_acknowledge[0] !=
		s_q.ctl[0][F_AL]) && s_q.ph != DCC_SINGLE |->
		(s_q.ctl[0][F_AM] ? mem_write : mem_read))
		else $error("acknowledge in wrong cycle");
	steal_gap_a: assert property (dual_s ##0
		!s_q.ctl[s_q.ch][F_TM] |=> !mem_read && !mem_write)
		else $error("cycle steal did not release the bus");
	size_a: assert property (mem_read |->
		mem_word == s_q.ctl[s_q.ch][F_TS])
		else $error("transfer size differs from size bit");
	word_align_a: assert property (mem_read && mem_word |->
		!mem_addr[0])
		else $error("word access on odd address");

endmodule : dcc_top

`default_nettype wire

//--- hdl/dcc_pkg.sv
// constants and types shared by the dma channel control block
package dcc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int AW = 28;
	localparam logic [AW-1:0] OFS_OPCTL = 28'h5FFFF48;
	localparam logic [AW-1:0] OFS_CTL = 28'h5FFFF00;
	localparam logic [AW-1:0] OFS_CNT = 28'h5FFFF10;
	localparam logic [AW-1:0] OFS_SAR = 28'h5FFFF20;
	localparam logic [AW-1:0] OFS_DAR = 28'h5FFFF30;
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] OPCTL_RST = 16'h0000;

	// ------------------------------------------------------------
	// channel control fields
	// ------------------------------------------------------------
	localparam int F_DE = 0;
	localparam int F_TE = 1;
	localparam int F_IE = 2;
	localparam int F_TS = 3;
	localparam int F_TM = 4;
	localparam int F_DS = 5;
	localparam int F_AL = 6;
	localparam int F_AM = 7;
	localparam int F_RS = 8;
	localparam int F_SM = 12;
	localparam int F_DM = 14;

	// ------------------------------------------------------------
	// operation control fields
	// ------------------------------------------------------------
	localparam int F_DME = 0;
	localparam int F_NMI_ABORT_FLAG = 1;
	localparam int F_AE = 2;
	localparam int F_PR = 8;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [3:0] RS_EXT_DUAL = 4'h0;
	localparam logic [3:0] RS_RSVD0 = 4'h1;
	localparam logic [3:0] RS_EXT_TO_DEV = 4'h2;
	localparam logic [3:0] RS_EXT_FROM_DEV = 4'h3;
	localparam logic [3:0] RS_AUTO = 4'hC;
	localparam logic [3:0] RS_ADC = 4'hD;
	localparam logic [3:0] RS_RSVD1 = 4'hE;
	localparam logic [3:0] RS_RSVD2 = 4'hF;
	localparam logic [1:0] STEP_FIXED = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [1:0] STEP_RSVD = 2'h3;
	localparam logic [1:0] PR_FIXED0 = 2'h0;
	localparam logic [1:0] PR_FIXED1 = 2'h1;
	localparam logic [1:0] PR_ROUND = 2'h2;
	localparam logic [1:0] PR_ALT = 2'h3;
	// channel order lists, slot 0 highest
	localparam logic [7:0] ORDER_A = 8'h6C;
	localparam logic [7:0] ORDER_B = 8'h2D;

	typedef enum logic [2:0] {DCC_IDLE, DCC_READ, DCC_WRITE,
		DCC_SINGLE, DCC_GAP} dcc_phase_e;
	typedef enum logic [2:0] {SEL_NONE, SEL_OPCTL, SEL_CTL, SEL_CNT,
		SEL_SAR, SEL_DAR} dcc_sel_e;

endpackage : dcc_pkg

//--- hdl/dcc_arb.sv
// channel priority arbiter with fixed, rotating and alternating orders
`timescale 1ns/10ps
`default_nettype none

module dcc_arb
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// requests
	input wire logic [1:0] mode,
	input wire logic [3:0] req,
	input wire logic served,
	input wire logic [1:0] served_ch,
	// grant
	output logic grant_valid,
	output logic [1:0] grant_ch
);
	import dcc_pkg::*;

	typedef struct packed {
		logic [3:0][1:0] rr;
		logic [3:0][1:0] alt;
	} dcc_arb_s;

	dcc_arb_s s_q;
	dcc_arb_s s_d;
	logic [3:0][1:0] ord;
	logic [3:0][1:0] nrr;
	int j;

	// ------------------------------------------------------------
	// grant and order update
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (mode)
			PR_FIXED0: ord = ORDER_A;
			PR_FIXED1: ord = ORDER_B;
			PR_ROUND: ord = s_q.rr;
			PR_ALT: ord = s_q.alt;
		endcase
		grant_valid = 1'b0;
		grant_ch = ord[0];
		for (int k = 3; k >= 0; k--)
			if (req[ord[k]])
			begin
				grant_valid = 1'b1;
				grant_ch = ord[k];
			end
		s_d = s_q;
		nrr = s_q.rr;
		j = 0;
		for (int k = 0; k < 4; k++)
			if (s_q.rr[k] != served_ch)
			begin
				nrr[j[1:0]] = s_q.rr[k];
				j = j + 1;
			end
		nrr[3] = served_ch;
		// served channel drops to the lowest slot
		if (served && mode == PR_ROUND)
			s_d.rr = nrr;
		if (served && mode == PR_ALT)
			s_d.alt = (s_q.alt == ORDER_A) ? ORDER_B : ORDER_A;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q.rr <= ORDER_A;
			s_q.alt <= ORDER_B;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	fixed_zero_a: assert property (mode == PR_FIXED0 && req[0]
		|-> grant_valid && grant_ch == 2'h0)
		else $error("mode 0 did not grant channel 0");
	fixed_one_a: assert property (mode == PR_FIXED1 && req[1]
		|-> grant_valid && grant_ch == 2'h1)
		else $error("mode 1 did not grant channel 1");
	round_robin_a: assert property (served && mode == PR_ROUND
		|=> s_q.rr[3] == $past(served_ch))
		else $error("served channel not moved to lowest slot");
	alt_order_a: assert property (served && mode == PR_ALT
		|=> s_q.alt != $past(s_q.alt))
		else $error("alternating order did not switch");

endmodule : dcc_arb

`default_nettype wire

//--- dv/dcc_ext_dev.sv
// external requesting device model for one handshake channel
`timescale 1ns/10ps
`default_nettype none

module dcc_ext_dev
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// set up by the bench
	input wire logic arm,
	input wire logic edge_mode,
	input wire logic ack_low,
	// handshake pins
	input wire logic ack,
	output logic req_n
);
	typedef struct packed {
		logic req_n;
		logic waiting;
	} dcc_dev_s;
	dcc_dev_s st_q;
	dcc_dev_s st_d;

	// request held low until acknowledged, or a one-cycle low pulse
	always_comb
	begin
		st_d = st_q;
		if (ack ^ ack_low)
			st_d = '{req_n: 1'b1, waiting: 1'b0};
		else if (!st_q.req_n && edge_mode)
			st_d.req_n = 1'b1;
		else if (arm && !st_q.waiting)
			st_d = '{req_n: 1'b0, waiting: 1'b1};
	end

	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n)
			st_q <= '{req_n: 1'b1, waiting: 1'b0};
		else
			st_q <= st_d;

	assign req_n = st_q.req_n;
endmodule : dcc_ext_dev
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) chk((a) === (b), (a), (b))

module testbench;
	import dcc_pkg::*;
	logic mclk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [AW-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, mem_addr, q;
	logic [1:0] transfer_acknowledge, arm, edg, alow;
	wire [1:0] transfer_request_n;
	logic [2:0] ev;
	logic mem_read, mem_write, mem_word;
	logic [15:0] mem_rdata, mem_wdata;
	logic [3:0] channel_irq;
	logic [31:0] rq[$], wq[$], dq[$];
	int error_cnt, compares, a0r, a0w, a1w, wd;

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	dcc_top dut_u (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .transfer_request_n, .transfer_acknowledge,
		.sci_req_event(4'h0), .timer_match_a_event(3'h0),
		.timer3_match_a_event(ev[0]), .conversion_end_event(ev[1]),
		.nmi_event(ev[2]), .mem_addr, .mem_read, .mem_write, .mem_word,
		.mem_rdata, .mem_wdata, .channel_irq);

	dcc_ext_dev dev_u[1:0] (.mclk, .reset_n, .arm, .edge_mode(edg),
		.ack_low(alow), .ack(transfer_acknowledge),
		.req_n(transfer_request_n));

	// memory returns a pattern made from the address
	assign mem_rdata = mem_addr[15:0] ^ 16'h5A00;

	// -------------------------------
	// memory phase monitor
	// -------------------------------
	always @(negedge mclk)
	begin
		if (mem_read)
			rq.push_back(mem_addr);
		if (mem_write)
			wq.push_back(mem_addr);
		if (mem_write)
			dq.push_back({16'h0, mem_wdata});
		a0r += int'(mem_read && transfer_acknowledge[0] === 1'b1);
		a0w += int'(mem_write && transfer_acknowledge[0] === 1'b1);
		a1w += int'(mem_write && transfer_acknowledge[1] === 1'b0);
		wd += int'(mem_read && mem_word === 1'b1);
	end

	// -------------------------------
	// tasks
	// -------------------------------
	task automatic stop_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic chk(input logic ok, input logic [31:0] g,
		input logic [31:0] e);
		compares++;
		if (!ok)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t got %0h expected %0h", $time, g, e);
		end
	endtask : chk

	task automatic tmo;
		error_cnt++;
		$display("CHECK FAILED %0t wait ran out", $time);
		stop_test;
	endtask : tmo

	task automatic clr;
		rq.delete();
		wq.delete();
		dq.delete();
		a0r = 0;
		a0w = 0;
		a1w = 0;
		wd = 0;
	endtask : clr

	task automatic bus(input logic w, input logic [AW-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// wait for the edge at which waitrequest is seen low
		do
		begin
			@(posedge mclk);
			n++;
			if (n > 50)
				tmo;
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus

	function automatic logic [AW-1:0] ra(input logic [AW-1:0] b,
		input logic [1:0] ch);
		return b + {24'h0, ch, 2'h0};
	endfunction : ra

	task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e);
	endtask : rd_chk

	task automatic setup(input logic [1:0] ch, input logic [31:0] s,
		input logic [31:0] d, input logic [31:0] n, input logic [31:0] c);
		bus(1'b0, ra(OFS_CTL, ch), 32'h0);
		bus(1'b1, ra(OFS_SAR, ch), s);
		bus(1'b1, ra(OFS_DAR, ch), d);
		bus(1'b1, ra(OFS_CNT, ch), n);
		bus(1'b1, ra(OFS_CTL, ch), c);
	endtask : setup

	task automatic wait_ph(input int n);
		int k;
		for (k = 0; k < 400 && rq.size() + wq.size() < n; k++)
			@(posedge mclk);
		if (k == 400)
			tmo;
	endtask : wait_ph

	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge mclk);
		ev[i] <= 1'b0;
		@(posedge mclk);
	endtask : pulse

	task automatic do_reset;
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		clr;
	endtask : do_reset

	// -------------------------------
	// main sequence
	// -------------------------------
	initial
	begin
		static logic [3:0] rs[3] = '{4'h1, 4'hE, 4'hF};
		static logic [3:0] pat[4] = '{4'b1100, 4'b0011, 4'b1010, 4'b0101};
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{arm, edg, alow, ev} = '0;
		error_cnt = 0;
		compares = 0;
		reset_n = 1'b0;
		clr;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		rd_chk(OFS_OPCTL, 32'h0);
		for (int i = 0; i < 4; i++)
			rd_chk(ra(OFS_CTL, 2'(i)), 32'h0);
		rd_chk(OFS_OPCTL + 28'h38, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, OFS_CTL, {20'h0, rs[i], 8'h0});
			rd_chk(OFS_CTL, 32'h0);
		end
		bus(1'b1, OFS_CTL, 32'h7C00);
		rd_chk(OFS_CTL, 32'h4C00);
		bus(1'b1, ra(OFS_CTL, 2'h2), 32'hE0);
		rd_chk(ra(OFS_CTL, 2'h2), 32'h0);
		bus(1'b1, OFS_CTL, 32'hE0);
		rd_chk(OFS_CTL, 32'hE0);
		setup(2'h0, 32'h1000, 32'h2000, 32'h2, 32'h5C05);
		repeat (20) @(posedge mclk);
		`CHK(wq.size(), 0);
		bus(1'b1, OFS_OPCTL, 32'h1);
		wait_ph(4);
		for (int i = 0; i < 2; i++)
		begin
			`CHK(rq[i], 32'h1000 + 32'(i));
			`CHK(wq[i], 32'h2000 + 32'(i));
		end
		`CHK(wd, 0);
		rd_chk(OFS_CNT, 32'h0);
		rd_chk(OFS_CTL, 32'h5C07);
		`CHK(channel_irq, 4'h1);
		bus(1'b1, OFS_CTL, 32'h5C06);
		bus(1'b1, OFS_CTL, 32'h5C04);
		rd_chk(OFS_CTL, 32'h5C06);
		bus(1'b1, OFS_CTL, 32'h5C04);
		rd_chk(OFS_CTL, 32'h5C04);
		`CHK(channel_irq, 4'h0);
		repeat (20) @(posedge mclk);
		`CHK(wq.size(), 2);
		pulse(2);
		rd_chk(OFS_OPCTL, 32'h3);
		setup(2'h0, 32'h1000, 32'h2000, 32'h1, 32'h5C05);
		repeat (20) @(posedge mclk);
		`CHK(wq.size(), 2);
		bus(1'b1, OFS_OPCTL, 32'h3);
		rd_chk(OFS_OPCTL, 32'h3);
		bus(1'b1, OFS_OPCTL, 32'h1);
		rd_chk(OFS_OPCTL, 32'h1);
		wait_ph(6);
		setup(2'h0, 32'h501, 32'h2000, 32'h1, 32'h1C09);
		repeat (10) @(posedge mclk);
		rd_chk(OFS_OPCTL, 32'h5);
		`CHK(wq.size(), 3);
		bus(1'b1, OFS_CTL, 32'h0);
		bus(1'b1, OFS_OPCTL, 32'h1);
		rd_chk(OFS_OPCTL, 32'h1);
		clr;
		setup(2'h0, 32'h600, 32'h700, 32'h2, 32'h5C09);
		wait_ph(4);
		for (int i = 0; i < 2; i++)
		begin
			`CHK(rq[i], 32'h600 + 32'(2 * i));
			`CHK(wq[i], 32'h700 + 32'(2 * i));
			`CHK(dq[i], 32'h5A00 ^ (32'h600 + 32'(2 * i)));
		end
		`CHK(wd, 2);
		clr;
		setup(2'h2, 32'hB00, 32'hE00, 32'h1, 32'h0B01);
		setup(2'h3, 32'hD00, 32'hE00, 32'h1, 32'h0D01);
		repeat (10) @(posedge mclk);
		`CHK(rq.size(), 0);
		`CHK(channel_irq, 4'h0);
		pulse(0);
		wait_ph(2);
		`CHK(rq[0], 32'hB00);
		pulse(1);
		wait_ph(4);
		`CHK(rq[1], 32'hD00);
		clr;
		setup(2'h1, 32'h0, 32'h800, 32'h2, 32'h4341);
		alow <= 2'h2;
		arm <= 2'h2;
		wait_ph(2);
		`CHK(wq[0], 32'h800);
		`CHK(wq[1], 32'h801);
		`CHK(rq.size(), 0);
		`CHK(a1w, 2);
		clr;
		setup(2'h0, 32'h900, 32'hA00, 32'h1, 32'h50A1);
		edg <= 2'h1;
		arm <= 2'h3;
		wait_ph(2);
		`CHK(rq[0], 32'h900);
		`CHK(wq[0], 32'hA00);
		`CHK(a0w, 1);
		`CHK(a0r, 0);
		arm <= 2'h0;
		for (int m = 0; m < 4; m++)
		begin
			do_reset;
			setup(2'h0, 32'h100, 32'h400, 32'h2, 32'h0C01);
			setup(2'h1, 32'h300, 32'h400, 32'h2, 32'h0C01);
			bus(1'b1, OFS_OPCTL, {22'h0, 2'(m), 8'h01});
			wait_ph(8);
			for (int i = 0; i < 4; i++)
				`CHK(rq[i], pat[m][i] ? 32'h300 : 32'h100);
		end
		stop_test;
	end
endmodule : testbench
`default_nettype wire
